// >>> power_up_seq_pkg.sv
// Purpose: Shared constants and types for the power-up and enable sequencer.
// Assumes: A 200 MHz core clock and input supply samples in 10 mV units.
// Notes:   Threshold figures are held in 10 mV units.
package power_up_seq_pkg;

  localparam int CLK_PERIOD_PS = 5000;
  localparam int BLANK_TIME_US = 150;
  // Longest time, so the division rounds down.
  localparam int BLANK_CYCLES  = (BLANK_TIME_US * 1000000) / CLK_PERIOD_PS;

  localparam int VIN_W     = 12;
  localparam int LEVEL_W   = 4;
  localparam int BLANK_W   = 16;
  localparam int FAULT_N   = 4;

  localparam logic [LEVEL_W-1:0] LOCKOUT_LEVEL_RST = 4'h0;
  localparam logic [LEVEL_W-1:0] LOCKOUT_CODE_MAX  = 4'ha;
  localparam logic [VIN_W-1:0]   LOCKOUT_BASE_CV   = 12'h1c2;
  localparam logic [VIN_W-1:0]   LOCKOUT_STEP_CV   = 12'h028;

  typedef enum logic [1:0] {
    ST_OFF       = 2'b00,
    ST_WAIT_BIAS = 2'b01,
    ST_ON        = 2'b10
  } seq_state_e;

endpackage

// >>> lockout_blanker.sv
// Purpose: Blanks the raw input undervoltage condition for a fixed interval.
// Assumes: Raw condition is synchronous to clk.
// Notes:   Release is immediate; only the assertion is delayed.
`timescale 1ns/1ps
`default_nettype none
module lockout_blanker
  import power_up_seq_pkg::*;
#(
  parameter int BLANK_LEN = BLANK_CYCLES
)(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic raw_low,
  output logic      blanked_low
);

  logic [BLANK_W-1:0] cnt_ff;
  logic [BLANK_W-1:0] nxt_cnt;
  logic               low_ff;
  logic               nxt_low;

  always_comb
  begin
    nxt_cnt = '0;
    nxt_low = 1'b0;
    if (raw_low)
    begin
      nxt_low = low_ff;
      nxt_cnt = cnt_ff;
      if (cnt_ff >= BLANK_W'(BLANK_LEN - 1))
        nxt_low = 1'b1;
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // Start up in lockout so the converter stays off until a clean sample.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= '0;
      low_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      low_ff <= nxt_low;
    end
  end

  assign blanked_low = low_ff;

  a_blank_no_early: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(low_ff) |-> cnt_ff == BLANK_W'(BLANK_LEN - 1))
    else $error("Lockout asserted before the blanking interval ended.");

  a_blank_release: assert property (@(posedge clk) disable iff (!arst_n)
    !raw_low |=> !low_ff && cnt_ff == '0)
    else $error("Lockout did not release with the supply.");

endmodule
`default_nettype wire

// >>> power_up_sequencer.sv
// Purpose: Power-up and enable sequencing with programmable input lockout.
// Assumes: All inputs synchronous to clk; bias comparators are levels.
// Notes:   The alert pin is open-drain; alert_oe high pulls it low.
`timescale 1ns/1ps
`default_nettype none
module power_up_sequencer
  import power_up_seq_pkg::*;
#(
  parameter int BLANK_LEN = BLANK_CYCLES
)(
  input  wire logic                                  clk,
  input  wire logic                                  arst_n,
  input  wire logic                                  high_voltage_enable,
  input  wire logic                                  bias_above_rise,
  input  wire logic                                  bias_above_fall,
  input  wire logic [power_up_seq_pkg::VIN_W-1:0]   vin_sample_cv,
  input  wire logic [power_up_seq_pkg::LEVEL_W-1:0] input_lockout_level,
  input  wire logic [power_up_seq_pkg::FAULT_N-1:0] fault_src,
  input  wire logic [power_up_seq_pkg::FAULT_N-1:0] fault_mask,
  input  wire logic                                  alert_ack,
  output logic                                       off_mode,
  output logic                                       core_on,
  output logic                                       buck_boost_en,
  output logic                                       supply_lockout,
  output logic                                       alert_o,
  output logic                                       alert_oe
);
  import power_up_seq_pkg::*;

  function automatic logic [VIN_W-1:0] level_to_cv(
    input logic [LEVEL_W-1:0] code
  );
    logic [LEVEL_W-1:0] c;
    c = (code > LOCKOUT_CODE_MAX) ? LOCKOUT_CODE_MAX : code;
    level_to_cv = LOCKOUT_BASE_CV + VIN_W'(c * LOCKOUT_STEP_CV);
  endfunction

  seq_state_e         state_ff;
  seq_state_e         nxt_state;
  logic [LEVEL_W-1:0] level_ff;
  logic [LEVEL_W-1:0] nxt_level;
  logic [VIN_W-1:0]   thr_ff;
  logic [VIN_W-1:0]   nxt_thr;
  logic               raw_low_ff;
  logic               nxt_raw_low;
  logic               uv_blanked;
  logic               done_seen_ff;
  logic               nxt_done_seen;
  logic               up_flag_ff;
  logic               nxt_up_flag;
  logic               off_ff;
  logic               nxt_off;
  logic               core_ff;
  logic               nxt_core;
  logic               bb_ff;
  logic               nxt_bb;
  logic               lock_ff;
  logic               nxt_lock;
  logic               oe_ff;
  logic               nxt_oe;
  logic               done_evt;
  logic               fault_any;

  lockout_blanker #(
    .BLANK_LEN (BLANK_LEN)
  ) u_blank (
    .clk         (clk),
    .arst_n      (arst_n),
    .raw_low     (raw_low_ff),
    .blanked_low (uv_blanked)
  );

  always_comb
  begin
    // level follows the input every cycle
    nxt_level   = input_lockout_level;
    nxt_thr     = level_to_cv(level_ff);
    nxt_raw_low = vin_sample_cv < thr_ff;
  end

  // Sequencer state.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF:
      begin
        if (high_voltage_enable)
          nxt_state = ST_WAIT_BIAS;
      end
      // start needs bias and enable together
      ST_WAIT_BIAS:
      begin
        if (!high_voltage_enable)
          nxt_state = ST_OFF;
        else if (bias_above_rise)
          nxt_state = ST_ON;
      end
      // shutdown on enable low or bias fall
      ST_ON:
      begin
        if (!high_voltage_enable || !bias_above_fall)
          nxt_state = ST_OFF;
      end
      default:
        nxt_state = ST_OFF;
    endcase
  end

  assign done_evt  = (state_ff == ST_ON) && !uv_blanked && !done_seen_ff;
  assign fault_any = |(fault_src & ~fault_mask);

  always_comb
  begin
    nxt_done_seen = (state_ff == ST_ON) && (done_seen_ff || done_evt);
    // set wins over the host acknowledge
    nxt_up_flag   = done_evt || (up_flag_ff && !alert_ack);
    nxt_off       = (nxt_state == ST_OFF);
    nxt_core      = (nxt_state == ST_ON);
    nxt_bb        = (state_ff == ST_ON) && (nxt_state == ST_ON) && !uv_blanked;
    nxt_lock      = uv_blanked;
    // alert from done, or from any unmasked fault while in ST_ON
    nxt_oe        = nxt_up_flag || (fault_any && (state_ff == ST_ON));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff     <= ST_OFF;
      level_ff     <= LOCKOUT_LEVEL_RST;
      thr_ff       <= LOCKOUT_BASE_CV;
      raw_low_ff   <= 1'b1;
      done_seen_ff <= 1'b0;
      up_flag_ff   <= 1'b0;
      off_ff       <= 1'b1;
      core_ff      <= 1'b0;
      bb_ff        <= 1'b0;
      lock_ff      <= 1'b1;
      oe_ff        <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      level_ff     <= nxt_level;
      thr_ff       <= nxt_thr;
      raw_low_ff   <= nxt_raw_low;
      done_seen_ff <= nxt_done_seen;
      up_flag_ff   <= nxt_up_flag;
      off_ff       <= nxt_off;
      core_ff      <= nxt_core;
      bb_ff        <= nxt_bb;
      lock_ff      <= nxt_lock;
      oe_ff        <= nxt_oe;
    end
  end

  // Open-drain pin only ever pulls low; the flop keeps the output registered.
  logic alert_lvl_ff;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      alert_lvl_ff <= 1'b0;
    else
      alert_lvl_ff <= 1'b0;
  end

  assign off_mode       = off_ff;
  assign core_on        = core_ff;
  assign buck_boost_en  = bb_ff;
  assign supply_lockout = lock_ff;
  assign alert_o        = alert_lvl_ff;
  assign alert_oe       = oe_ff;

  sequence s_done;
    (state_ff == ST_ON) && !uv_blanked && !done_seen_ff;
  endsequence

  // The flag and the pin enable rise on the same edge.
  sequence s_alert_low;
    ##1 (up_flag_ff && oe_ff);
  endsequence

  a_alert_done: assert property (@(posedge clk) disable iff (!arst_n)
    s_done |-> s_alert_low)
    else $error("Alert did not assert after power-up completed.");

  a_off_disabled: assert property (@(posedge clk) disable iff (!arst_n)
    !high_voltage_enable |=> off_ff && !core_ff && !bb_ff)
    else $error("Block not off while enable is low.");

  a_bb_lockout: assert property (@(posedge clk) disable iff (!arst_n)
    uv_blanked |=> !bb_ff)
    else $error("Converter on during input lockout.");

  a_thr_range: assert property (@(posedge clk) disable iff (!arst_n)
    thr_ff >= LOCKOUT_BASE_CV && thr_ff <= 12'h352)
    else $error("Lockout threshold outside 4.5V to 8.5V.");

  a_level_live: assert property (@(posedge clk) disable iff (!arst_n)
    input_lockout_level == 4'h1 ##1 input_lockout_level == 4'h1
      |=> thr_ff == 12'h1ea)
    else $error("New lockout level did not take effect.");

  a_code_sat: assert property (@(posedge clk) disable iff (!arst_n)
    level_ff > LOCKOUT_CODE_MAX |=> thr_ff == 12'h352)
    else $error("High lockout code did not saturate.");

  a_start_cond: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(core_ff) |-> $past(bias_above_rise) && $past(high_voltage_enable))
    else $error("Started without bias and enable together.");

  a_bias_shutdown: assert property (@(posedge clk) disable iff (!arst_n)
    core_ff && !bias_above_fall |=> !core_ff ##1 !bb_ff)
    else $error("No shutdown after bias fell.");

  a_fault_alert: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == ST_ON) && |(fault_src & ~fault_mask) |=> oe_ff)
    else $error("Unmasked fault did not assert alert.");

endmodule
`default_nettype wire

// >>> host_side_model.sv
// Purpose: Enable source and I2C host facing the sequencer.
// Assumes: Alert is open drain with a pull-up on the host I/O supply.
// Notes:   The ack delay lets a scenario answer promptly or slowly.
`timescale 1ns/1ps
`default_nettype none
module host_side_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       enable_cmd,
  input  wire logic [3:0] ack_delay,
  input  wire logic       alert_o,
  input  wire logic       alert_oe,
  output logic            high_voltage_enable,
  output logic            alert_ack,
  output logic            alert_line
);
  logic [3:0] wait_cnt;
  logic       answered;

  // The pull-up wins whenever the device lets go of the pin.
  assign alert_line = alert_oe ? alert_o : 1'b1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      high_voltage_enable <= 1'b0;
      alert_ack           <= 1'b0;
      wait_cnt            <= 4'h0;
      answered            <= 1'b0;
    end
    else
    begin
      high_voltage_enable <= enable_cmd;
      alert_ack           <= 1'b0;
      if (alert_line)
      begin
        wait_cnt <= 4'h0;
        answered <= 1'b0;
      end
      else if (!answered)
      begin
        if (wait_cnt == ack_delay)
        begin
          alert_ack <= 1'b1;
          answered  <= 1'b1;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test_power_up_enable_sequencer.sv
// Purpose: Self-checking bench for the power-up sequencer.
// Assumes: The blanking count is shortened to 8 cycles.
// Notes:   Supply samples are in 10 mV units.
`timescale 1ns/1ps
`default_nettype none
module test_power_up_enable_sequencer;
  import power_up_seq_pkg::*;
  logic               clk, arst_n, enable_cmd, high_voltage_enable;
  logic               bias_above_rise, bias_above_fall, alert_ack;
  logic               off_mode, core_on, buck_boost_en, supply_lockout;
  logic               alert_o, alert_oe, alert_line;
  logic [VIN_W-1:0]   vin_sample_cv;
  logic [LEVEL_W-1:0] input_lockout_level;
  logic [FAULT_N-1:0] fault_src, fault_mask;
  logic [3:0]         ack_delay;
  int                 miscompares, samples_checked;

  power_up_sequencer #(.BLANK_LEN(8)) power_up_sequencer_inst (
    .clk, .arst_n, .high_voltage_enable, .bias_above_rise,
    .bias_above_fall, .vin_sample_cv, .input_lockout_level, .fault_src,
    .fault_mask, .alert_ack, .off_mode, .core_on, .buck_boost_en,
    .supply_lockout, .alert_o, .alert_oe);
  host_side_model host_side_model_inst (
    .clk, .arst_n, .enable_cmd, .ack_delay, .alert_o, .alert_oe,
    .high_voltage_enable, .alert_ack, .alert_line);

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wait_alert(input logic level, input int limit);
    int k;
    k = 0;
    while (alert_line !== level && k < limit)
    begin
      step(1);
      k++;
    end
    check(level, alert_line);
    if (alert_line !== level)
      tally_and_finish();
  endtask

  task automatic start_needs_bias();
    enable_cmd = 1'b1;
    step(10);
    check(1'b0, off_mode);
    check(1'b0, core_on);
    bias_above_rise = 1'b1;
    wait_alert(1'b0, 20);
    check(1'b1, core_on);
    check(1'b1, buck_boost_en);
    step(3);
    check(1'b1, alert_oe);
    wait_alert(1'b1, 20);
  endtask

  task automatic dip_blanking();
    vin_sample_cv = 12'h190;
    step(6);
    vin_sample_cv = 12'h258;
    step(12);
    check(1'b0, supply_lockout);
    check(1'b1, buck_boost_en);
    vin_sample_cv = 12'h190;
    step(16);
    check(1'b1, supply_lockout);
    check(1'b0, buck_boost_en);
    check(1'b1, core_on);
    vin_sample_cv = 12'h258;
    step(6);
    check(1'b1, buck_boost_en);
  endtask

  task automatic level_sweep();
    logic [VIN_W-1:0] thr;
    for (int c = 0; c < 16; c++)
    begin
      thr = 12'h1c2 + 12'h028 * 12'(c > 10 ? 10 : c);
      input_lockout_level = 4'(c);
      vin_sample_cv = thr;
      step(16);
      check(1'b0, supply_lockout);
      vin_sample_cv = thr - 12'h001;
      step(16);
      check(1'b1, supply_lockout);
    end
    input_lockout_level = 4'h0;
    vin_sample_cv = 12'h258;
    step(6);
    check(1'b0, supply_lockout);
  endtask

  task automatic fault_masking();
    for (int i = 0; i < 4; i++)
    begin
      fault_src = 4'h1 << i;
      step(2);
      check(1'b1, alert_oe);
      fault_mask = 4'h1 << i;
      step(2);
      check(1'b0, alert_oe);
      fault_src = 4'h0;
      fault_mask = 4'h0;
      step(2);
    end
  endtask

  task automatic shutdown_paths();
    bias_above_rise = 1'b0;
    bias_above_fall = 1'b0;
    step(3);
    check(1'b0, core_on);
    check(1'b0, buck_boost_en);
    bias_above_fall = 1'b1;
    step(4);
    check(1'b0, core_on);
    // The source passes enable through a flop, so let the low level reach
    // the pin before bias rises; otherwise a start would still be legal.
    enable_cmd = 1'b0;
    step(2);
    bias_above_rise = 1'b1;
    step(4);
    check(1'b1, off_mode);
    check(1'b0, core_on);
    enable_cmd = 1'b1;
    wait_alert(1'b0, 20);
    enable_cmd = 1'b0;
    step(4);
    check(1'b0, core_on);
    check(1'b1, off_mode);
  endtask

  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    enable_cmd = 1'b0;
    bias_above_rise = 1'b0;
    bias_above_fall = 1'b1;
    vin_sample_cv = 12'h258;
    input_lockout_level = 4'h0;
    fault_src = 4'h0;
    fault_mask = 4'h0;
    ack_delay = 4'h6;
    step(6);
    arst_n = 1'b1;
    check(1'b1, off_mode);
    check(1'b0, buck_boost_en);
    check(1'b0, alert_oe);
    check(1'b0, alert_o);
    start_needs_bias();
    dip_blanking();
    level_sweep();
    ack_delay = 4'h0;
    fault_masking();
    shutdown_paths();
    tally_and_finish();
  end
endmodule
`default_nettype wire
